// file: hw/acc_target.sv
/*
 * accelerometer end: bus target, register file, output refresh
 * assumes: axis samples come from logic on clk_i; bus lines and
 * address select strap are asynchronous pins
 */
//
// Behaviour
// - controller writes address, then register pointer
// - target acks write address and pointer
// - controller resends address with read direction
// - target acks read address, drives pointed register
// - controller nacks last read byte, then stops
// - pointer advances per read byte; controller acks
// - bytes shift out most significant bit first
// - receiver may hold clock low; sender waits; the target here also holds the clock low when it is the sender
// - single write: address, pointer, data, all acked
// - multi-byte write; every data byte acked
// - 20 user registers; reserved gaps between
// - 12 valid bits if resolution set, else 8
// - axis outputs are two's complement counts
// - refresh per rate period, never during reads
// - controller clears operate enable before config
// - count weight follows range and resolution
// - target address 000111 plus select pin
// - pointer byte most significant bit is zero
// - multi-byte write increments pointer per byte
`timescale 1ns/1ps
`default_nettype none
`include "acc_cfg.svh"
module acc_target #(
	parameter int unsigned RATE_BASE = `ACC_RATE_BASE_CYC,
	parameter logic [7:0] PART_ID = 8'h5a // arbitrary value
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	acc_bus_if.tgt bus,
	input wire logic addr_sel_i,
	input wire logic [11:0] axis_x_i,
	input wire logic [11:0] axis_y_i,
	input wire logic [11:0] axis_z_i,
	output acc_pkg::acc_byte_t control_primary_o,
	output acc_pkg::acc_byte_t rate_cfg_o,
	output logic data_ready_o
);
	import acc_pkg::*;
	acc_tgt_st_t st_q;
	acc_kind_t kind_q;
	logic [3:0] cnt_q;
	logic [7:0] sh_q;
	logic [6:0] ptr_q;
	logic rd_q;
	logic ack_q;
	logic sda_oe_q;
	logic scl_oe_q;
	logic [2:0] str_q;
	logic asel_m_q;
	logic asel_q;
	logic [7:0] rw_q [0:7];
	logic [11:0] out_q [0:2];
	logic pend_q;
	logic drdy_q;
	logic [23:0] rate_cnt_q;
	logic scl_s;
	logic sda_s;
	logic rise;
	logic fall;
	logic start;
	logic stop;
	logic byte_end;
	logic tx_load;
	logic wr_en;
	logic addr_hit;
	logic rate_tick;
	logic [23:0] period;
	logic [3:0] slot_r;
	logic [3:0] slot_w;
	logic [7:0] rd_val;
	// ==========================================
	// line conditioning
	acc_line_sync u_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.scl_i(bus.scl),
		.sda_i(bus.sda),
		.scl_o(scl_s),
		.sda_o(sda_s),
		.rise_o(rise),
		.fall_o(fall),
		.start_o(start),
		.stop_o(stop)
	);
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			asel_m_q <= 1'b0;
			asel_q <= 1'b0;
		end else begin
			asel_m_q <= addr_sel_i;
			asel_q <= asel_m_q;
		end
	end
	// ==========================================
	// register decode
	function automatic logic [3:0] rw_slot(input logic [6:0] a);
		case (a)
			`ACC_REG_CTL1: rw_slot = 4'h8;
			`ACC_REG_CTL2: rw_slot = 4'h9;
			`ACC_REG_ICFG1: rw_slot = 4'ha;
			`ACC_REG_ICFG2: rw_slot = 4'hb;
			`ACC_REG_RATE: rw_slot = 4'hc;
			`ACC_REG_WTMR: rw_slot = 4'hd;
			`ACC_REG_STEST: rw_slot = 4'he;
			`ACC_REG_WTHR: rw_slot = 4'hf;
			default: rw_slot = 4'h0;
		endcase
	endfunction
	assign slot_r = rw_slot(ptr_q);
	assign slot_w = rw_slot(ptr_q);
	always_comb begin
		rd_val = 8'h00;
		if (slot_r[3]) begin
			rd_val = rw_q[slot_r[2:0]];
		end else begin
			case (ptr_q)
				`ACC_REG_X_LOW: rd_val = {out_q[0][3:0], 4'h0};
				`ACC_REG_X_HIGH: rd_val = out_q[0][11:4];
				`ACC_REG_Y_LOW: rd_val = {out_q[1][3:0], 4'h0};
				`ACC_REG_Y_HIGH: rd_val = out_q[1][11:4];
				`ACC_REG_Z_LOW: rd_val = {out_q[2][3:0], 4'h0};
				`ACC_REG_Z_HIGH: rd_val = out_q[2][11:4];
				`ACC_REG_COMM: rd_val = `ACC_COMM_VALUE;
				`ACC_REG_PART_ID: rd_val = PART_ID;
				`ACC_REG_IRQ_PRI, `ACC_REG_IRQ_SUM: begin
					rd_val[`ACC_DRDY_BIT] = drdy_q;
				end
				default: rd_val = 8'h00;
			endcase
		end
	end
	// ==========================================
	// byte engine
	assign byte_end = (st_q == ACC_T_RX) && (cnt_q == 4'd8) && fall;
	assign addr_hit = sh_q[7:1] == {`ACC_ADDR_FIXED, asel_q};
	assign wr_en = byte_end && (kind_q == ACC_K_DATA);
	assign tx_load = fall && (((st_q == ACC_T_RX_ACK) && rd_q) ||
		((st_q == ACC_T_TX_ACK) && ack_q));
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q <= ACC_T_IDLE;
			kind_q <= ACC_K_ADDR;
			cnt_q <= 4'd0;
			sh_q <= 8'h00;
			ptr_q <= 7'h00;
			rd_q <= 1'b0;
			ack_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else if (stop) begin
			st_q <= ACC_T_IDLE;
			sda_oe_q <= 1'b0;
		end else if (start) begin
			st_q <= ACC_T_RX;
			kind_q <= ACC_K_ADDR;
			cnt_q <= 4'd0;
			sda_oe_q <= 1'b0;
		end else begin
			case (st_q)
				ACC_T_RX: begin
					if (rise && cnt_q != 4'd8) begin
						sh_q <= {sh_q[6:0], sda_s};
						cnt_q <= cnt_q + 4'd1;
					end
					if (byte_end) begin
						st_q <= ACC_T_RX_ACK;
						sda_oe_q <= 1'b1;
						case (kind_q)
							ACC_K_ADDR: begin
								rd_q <= sh_q[0];
								kind_q <= ACC_K_PTR;
								if (!addr_hit) begin
									st_q <= ACC_T_IDLE;
									sda_oe_q <= 1'b0;
								end
							end
							ACC_K_PTR: begin
								ptr_q <= sh_q[6:0];
								kind_q <= ACC_K_DATA;
							end
							default: ptr_q <= ptr_q + 7'd1;
						endcase
					end
				end
				ACC_T_RX_ACK: begin
					if (fall) begin
						cnt_q <= 4'd0;
						sda_oe_q <= 1'b0;
						st_q <= rd_q ? ACC_T_TX : ACC_T_RX;
					end
				end
				ACC_T_TX: begin
					if (fall && cnt_q == 4'd8) begin
						sda_oe_q <= 1'b0;
						st_q <= ACC_T_TX_ACK;
					end else if (fall) begin
						sda_oe_q <= !sh_q[6];
						sh_q <= {sh_q[6:0], 1'b0};
						cnt_q <= cnt_q + 4'd1;
					end
				end
				ACC_T_TX_ACK: begin
					if (rise) begin
						ack_q <= !sda_s;
					end
					if (fall) begin
						st_q <= ack_q ? ACC_T_TX : ACC_T_IDLE;
					end
				end
				default: st_q <= ACC_T_IDLE;
			endcase
			if (tx_load) begin
				sh_q <= rd_val;
				sda_oe_q <= !rd_val[7];
				cnt_q <= 4'd1;
				ptr_q <= ptr_q + 7'd1;
			end
		end
	end
	// ==========================================
	// clock stretch while a byte is staged
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			str_q <= 3'd0;
			scl_oe_q <= 1'b0;
		end else if (tx_load || (byte_end && st_q == ACC_T_RX)) begin
			str_q <= 3'(`ACC_STRETCH_CYC);
			scl_oe_q <= 1'b1;
		end else if (str_q != 3'd0) begin
			str_q <= str_q - 3'd1;
			scl_oe_q <= str_q != 3'd1;
		end else begin
			scl_oe_q <= 1'b0;
		end
	end
	// ==========================================
	// writable registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < 8; i++) begin
				rw_q[i] <= `ACC_RW_RESET;
			end
		end else if (wr_en && slot_w[3]) begin
			rw_q[slot_w[2:0]] <= sh_q;
		end
	end
	// ==========================================
	// output refresh and data-ready flag
	assign period = 24'(RATE_BASE) << rw_q[4][`ACC_RATE_MSB:0];
	assign rate_tick = rate_cnt_q >= period - 24'd1;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rate_cnt_q <= 24'd0;
		end else if (!rw_q[0][`ACC_CTL1_OPEN_BIT] || rate_tick) begin
			rate_cnt_q <= 24'd0;
		end else begin
			rate_cnt_q <= rate_cnt_q + 24'd1;
		end
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pend_q <= 1'b0;
			for (int i = 0; i < 3; i++) begin
				out_q[i] <= 12'h000;
			end
		end else if (st_q != ACC_T_IDLE) begin
			pend_q <= pend_q || (rate_tick && rw_q[0][`ACC_CTL1_OPEN_BIT]);
		end else if (pend_q || (rate_tick && rw_q[0][`ACC_CTL1_OPEN_BIT])) begin
			pend_q <= 1'b0;
			if (rw_q[0][`ACC_CTL1_RES_BIT]) begin
				out_q[0] <= axis_x_i;
				out_q[1] <= axis_y_i;
				out_q[2] <= axis_z_i;
			end else begin
				out_q[0] <= {axis_x_i[11:4], 4'h0};
				out_q[1] <= {axis_y_i[11:4], 4'h0};
				out_q[2] <= {axis_z_i[11:4], 4'h0};
			end
		end
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			drdy_q <= 1'b0;
		end else if (st_q == ACC_T_IDLE && (pend_q || (rate_tick &&
			rw_q[0][`ACC_CTL1_OPEN_BIT]))) begin
			drdy_q <= 1'b1;
		end else if (tx_load && (ptr_q == `ACC_REG_IRQ_REL ||
			(ptr_q >= `ACC_REG_X_LOW && ptr_q <= `ACC_REG_Z_HIGH))) begin
			drdy_q <= 1'b0;
		end
	end
	assign bus.t_sda_o = 1'b0;
	assign bus.t_sda_oe = sda_oe_q;
	assign bus.t_scl_o = 1'b0;
	assign bus.t_scl_oe = scl_oe_q;
	assign control_primary_o = rw_q[0];
	assign rate_cfg_o = rw_q[4];
	assign data_ready_o = drdy_q;
endmodule
`default_nettype wire

// file: include/acc_cfg.svh
/*
 * constants of the accelerometer serial register port
 * assumes: included by the package and by each design file that uses its macros
 */
`ifndef ACC_CFG_SVH
`define ACC_CFG_SVH
// ==========================================
// timing
`define ACC_CLK_NS 50
`define ACC_SCL_PERIOD_NS 2000
`define ACC_STRETCH_CYC 4
`define ACC_RATE_BASE_CYC 1000
// ==========================================
// bus address and direction
`define ACC_ADDR_FIXED 6'h07
`define ACC_DIR_WR 1'b0
`define ACC_DIR_RD 1'b1
// ==========================================
// register offsets
`define ACC_REG_X_LOW 7'h06
`define ACC_REG_X_HIGH 7'h07
`define ACC_REG_Y_LOW 7'h08
`define ACC_REG_Y_HIGH 7'h09
`define ACC_REG_Z_LOW 7'h0a
`define ACC_REG_Z_HIGH 7'h0b
`define ACC_REG_COMM 7'h0c
`define ACC_REG_PART_ID 7'h0f
`define ACC_REG_IRQ_PRI 7'h16
`define ACC_REG_IRQ_AXIS 7'h17
`define ACC_REG_IRQ_SUM 7'h18
`define ACC_REG_IRQ_REL 7'h1a
`define ACC_REG_CTL1 7'h1b
`define ACC_REG_CTL2 7'h1d
`define ACC_REG_ICFG1 7'h1e
`define ACC_REG_ICFG2 7'h1f
`define ACC_REG_RATE 7'h21
`define ACC_REG_WTMR 7'h29
`define ACC_REG_STEST 7'h3a
`define ACC_REG_WTHR 7'h6a
// ==========================================
// fields and values
`define ACC_CTL1_OPEN_BIT 7
`define ACC_CTL1_RES_BIT 6
`define ACC_RATE_MSB 2
`define ACC_DRDY_BIT 4
`define ACC_COMM_VALUE 8'h55
`define ACC_RW_RESET 8'h00
`endif

// file: include/acc_pkg.sv
/*
 * types of the accelerometer serial register port
 * assumes: acc_cfg.svh is on the include path
 */
`default_nettype none
package acc_pkg;
`include "acc_cfg.svh"
	typedef logic [7:0] acc_byte_t;
	typedef enum logic [2:0] {
		ACC_T_IDLE = 3'b000,
		ACC_T_RX = 3'b001,
		ACC_T_RX_ACK = 3'b010,
		ACC_T_TX = 3'b011,
		ACC_T_TX_ACK = 3'b100
	} acc_tgt_st_t;
	typedef enum logic [1:0] {
		ACC_K_ADDR = 2'b00,
		ACC_K_PTR = 2'b01,
		ACC_K_DATA = 2'b10
	} acc_kind_t;
	typedef enum logic [1:0] {
		ACC_C_IDLE = 2'b00,
		ACC_C_START = 2'b01,
		ACC_C_BYTE = 2'b10,
		ACC_C_STOP = 2'b11
	} acc_ctl_st_t;
	typedef enum logic [2:0] {
		ACC_S_AW = 3'b000,
		ACC_S_PTR = 3'b001,
		ACC_S_DATA = 3'b010,
		ACC_S_AR = 3'b011,
		ACC_S_RECV = 3'b100
	} acc_step_t;
endpackage
`default_nettype wire

// file: include/acc_bus_if.sv
/*
 * two-wire bus between controller and accelerometer target
 * assumes: pull-ups; a line is low while any enabled driver drives low
 */
`timescale 1ns/1ps
`default_nettype none
interface acc_bus_if;
	logic c_scl_o;
	logic c_scl_oe;
	logic c_sda_o;
	logic c_sda_oe;
	logic t_scl_o;
	logic t_scl_oe;
	logic t_sda_o;
	logic t_sda_oe;
	logic scl;
	logic sda;
	// ==========================================
	// wired-and resolution
	assign scl = !((c_scl_oe && !c_scl_o) || (t_scl_oe && !t_scl_o));
	assign sda = !((c_sda_oe && !c_sda_o) || (t_sda_oe && !t_sda_o));
	modport tgt(input scl, sda, output t_scl_o, t_scl_oe, t_sda_o,
		t_sda_oe);
	modport ctl(input scl, sda, output c_scl_o, c_scl_oe, c_sda_o,
		c_sda_oe);
endinterface
`default_nettype wire

// file: hw/acc_line_sync.sv
/*
 * synchroniser and condition detector for the two bus lines
 * assumes: lines are asynchronous to clk_i
 */
`timescale 1ns/1ps
`default_nettype none
module acc_line_sync (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o,
	output logic rise_o,
	output logic fall_o,
	output logic start_o,
	output logic stop_o
);
	logic scl_m_q;
	logic sda_m_q;
	logic scl_s_q;
	logic sda_s_q;
	logic scl_p_q;
	logic sda_p_q;
	// ==========================================
	// two stages, then one for edges
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scl_m_q <= 1'b1;
			sda_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			sda_s_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_m_q <= scl_i;
			sda_m_q <= sda_i;
			scl_s_q <= scl_m_q;
			sda_s_q <= sda_m_q;
			scl_p_q <= scl_s_q;
			sda_p_q <= sda_s_q;
		end
	end
	assign scl_o = scl_s_q;
	assign sda_o = sda_s_q;
	assign rise_o = scl_s_q && !scl_p_q;
	assign fall_o = !scl_s_q && scl_p_q;
	assign start_o = scl_s_q && scl_p_q && !sda_s_q && sda_p_q;
	assign stop_o = scl_s_q && scl_p_q && sda_s_q && !sda_p_q;
endmodule
`default_nettype wire

// file: hw/acc_ctrl.sv
/*
 * controller end: drives start, address, pointer, data, stop
 * assumes: user holds command fields while cmd_vld_i pulses
 */
`timescale 1ns/1ps
`default_nettype none
`include "acc_cfg.svh"
module acc_ctrl #(
	parameter int unsigned QCYC = `ACC_SCL_PERIOD_NS / (4 * `ACC_CLK_NS)
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	acc_bus_if.ctl bus,
	input wire logic cmd_vld_i,
	input wire logic cmd_rd_i,
	input wire logic cmd_sel_i,
	input wire acc_pkg::acc_byte_t cmd_ptr_i,
	input wire logic [7:0] cmd_len_i,
	input wire acc_pkg::acc_byte_t wdata_i,
	output logic busy_o,
	output logic wtake_o,
	output acc_pkg::acc_byte_t rdata_o,
	output logic rvld_o,
	output logic nack_o,
	output logic done_o
);
	import acc_pkg::*;
	acc_ctl_st_t st_q;
	acc_step_t step_q;
	logic [1:0] ph_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q;
	logic [7:0] len_q;
	logic [7:0] ptr_q;
	logic [15:0] q_q;
	logic rd_q;
	logic sel_q;
	logic ackb_q;
	logic scl_oe_q;
	logic sda_oe_q;
	logic scl_s;
	logic sda_s;
	logic tick;
	logic hold;
	logic adv;
	// ==========================================
	// line sampling and quarter-bit divider
	acc_line_sync u_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.scl_i(bus.scl),
		.sda_i(bus.sda),
		.scl_o(scl_s),
		.sda_o(sda_s),
		.rise_o(),
		.fall_o(),
		.start_o(),
		.stop_o()
	);
	assign tick = q_q >= 16'(QCYC - 1);
	assign hold = (ph_q == 2'd2 && !scl_s) ||
		(st_q == ACC_C_START && ph_q == 2'd1 && !sda_s);
	assign adv = tick && !hold;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q_q <= 16'd0;
		end else if (st_q == ACC_C_IDLE || adv) begin
			q_q <= 16'd0;
		end else if (!tick) begin
			q_q <= q_q + 16'd1;
		end
	end
	// ==========================================
	// sequencer
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q <= ACC_C_IDLE;
			step_q <= ACC_S_AW;
			ph_q <= 2'd0;
			bit_q <= 4'd0;
			sh_q <= 8'h00;
			len_q <= 8'd0;
			ptr_q <= 8'h00;
			rd_q <= 1'b0;
			sel_q <= 1'b0;
			ackb_q <= 1'b0;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			busy_o <= 1'b0;
			wtake_o <= 1'b0;
			rdata_o <= 8'h00;
			rvld_o <= 1'b0;
			nack_o <= 1'b0;
			done_o <= 1'b0;
		end else begin
			wtake_o <= 1'b0;
			rvld_o <= 1'b0;
			done_o <= 1'b0;
			if (st_q == ACC_C_IDLE && cmd_vld_i) begin
				st_q <= ACC_C_START;
				step_q <= ACC_S_AW;
				ph_q <= 2'd0;
				sh_q <= {`ACC_ADDR_FIXED, cmd_sel_i, `ACC_DIR_WR};
				rd_q <= cmd_rd_i;
				sel_q <= cmd_sel_i;
				ptr_q <= {1'b0, cmd_ptr_i[6:0]};
				len_q <= cmd_len_i;
				nack_o <= 1'b0;
				busy_o <= 1'b1;
			end else if (st_q != ACC_C_IDLE && adv) begin
				ph_q <= ph_q + 2'd1;
				case (st_q)
					ACC_C_START: begin
						case (ph_q)
							2'd0: sda_oe_q <= 1'b0;
							2'd1: scl_oe_q <= 1'b0;
							2'd2: sda_oe_q <= 1'b1;
							default: begin
								scl_oe_q <= 1'b1;
								st_q <= ACC_C_BYTE;
								bit_q <= 4'd0;
							end
						endcase
					end
					ACC_C_BYTE: begin
						case (ph_q)
							2'd0: begin
								if (bit_q != 4'd8) begin
									sda_oe_q <= step_q != ACC_S_RECV && !sh_q[7];
								end else begin
									sda_oe_q <= step_q == ACC_S_RECV &&
										len_q != 8'd1;
								end
							end
							2'd1: scl_oe_q <= 1'b0;
							2'd2: begin
								if (bit_q != 4'd8) begin
									sh_q <= {sh_q[6:0], sda_s};
								end else begin
									ackb_q <= sda_s;
								end
							end
							default: begin
								scl_oe_q <= 1'b1;
								bit_q <= bit_q + 4'd1;
								if (bit_q == 4'd8) begin
									bit_q <= 4'd0;
									if (step_q != ACC_S_RECV && ackb_q) begin
										nack_o <= 1'b1;
										st_q <= ACC_C_STOP;
									end else begin
										case (step_q)
											ACC_S_AW: begin
												sh_q <= ptr_q;
												step_q <= ACC_S_PTR;
											end
											ACC_S_PTR: begin
												if (rd_q) begin
													st_q <= ACC_C_START;
													step_q <= ACC_S_AR;
													sh_q <= {`ACC_ADDR_FIXED, sel_q, `ACC_DIR_RD};
												end else begin
													sh_q <= wdata_i;
													wtake_o <= 1'b1;
													step_q <= ACC_S_DATA;
												end
											end
											ACC_S_DATA: begin
												len_q <= len_q - 8'd1;
												if (len_q <= 8'd1) begin
													st_q <= ACC_C_STOP;
												end else begin
													sh_q <= wdata_i;
													wtake_o <= 1'b1;
												end
											end
											ACC_S_AR: step_q <= ACC_S_RECV;
											default: begin
												rdata_o <= sh_q;
												rvld_o <= 1'b1;
												len_q <= len_q - 8'd1;
												if (len_q <= 8'd1) begin
													st_q <= ACC_C_STOP;
												end
											end
										endcase
									end
								end
							end
						endcase
					end
					ACC_C_STOP: begin
						case (ph_q)
							2'd0: sda_oe_q <= 1'b1;
							2'd1: scl_oe_q <= 1'b0;
							2'd2: sda_oe_q <= 1'b0;
							default: begin
								st_q <= ACC_C_IDLE;
								busy_o <= 1'b0;
								done_o <= 1'b1;
							end
						endcase
					end
					default: st_q <= ACC_C_IDLE;
				endcase
			end
		end
	end
	assign bus.c_scl_o = 1'b0;
	assign bus.c_scl_oe = scl_oe_q;
	assign bus.c_sda_o = 1'b0;
	assign bus.c_sda_oe = sda_oe_q;
endmodule
`default_nettype wire

// file: verification/acc_bus_checker.sv
/* checker of the two-wire link joining controller and target
 assumes: instantiated beside acc_bus_if, one clock, one reset */
`timescale 1ns/1ps
`default_nettype none
module acc_bus_checker (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic addr_sel_i,
	input wire logic t_scl_oe,
	input wire logic t_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	logic [3:0] cnt_q;
	logic [7:0] sh_q;
	logic first_q;
	logic hit_q;
	logic rd_q;
	logic me;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	assign me = sh_q[7:1] == {6'h07, addr_sel_i};
	// ====
	// bit position and address tracking
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			first_q <= 1'b0;
			hit_q <= 1'b0;
			rd_q <= 1'b0;
		end else if (scl && $fell(sda)) begin
			cnt_q <= 4'h0;
			first_q <= 1'b1;
		end else if ($rose(scl) && cnt_q == 4'h8) begin
			cnt_q <= 4'h0;
			first_q <= 1'b0;
			if (first_q) begin
				hit_q <= me;
				rd_q <= sh_q[0];
			end
		end else if ($rose(scl)) begin
			cnt_q <= cnt_q + 4'h1;
			sh_q <= {sh_q[6:0], sda};
		end
	end
	// ====
	// assertions
	sequence ack_slot;
		$rose(scl) && cnt_q == 4'h8;
	endsequence
	sequence bus_stop;
		scl && $rose(sda);
	endsequence
	addr_ack_a: assert property (
		ack_slot ##0 (first_q && me) |-> t_sda_oe)
		else $error("own address not acknowledged");
	addr_miss_a: assert property (
		ack_slot ##0 (first_q && !me) |-> !t_sda_oe)
		else $error("foreign address acknowledged");
	byte_ack_a: assert property (
		ack_slot ##0 (!first_q && hit_q && !rd_q) |-> t_sda_oe)
		else $error("written byte not acknowledged");
	rd_ack_a: assert property (
		ack_slot ##0 (!first_q && rd_q) |-> !t_sda_oe)
		else $error("target holds data in controller ack slot");
	idle_quiet_a: assert property (
		!first_q && !hit_q |-> !t_sda_oe && !t_scl_oe)
		else $error("unaddressed target drives the bus");
	stop_release_a: assert property (bus_stop |-> !t_sda_oe [*4])
		else $error("data line held after stop");
	stretch_len_a: assert property (
		$rose(t_scl_oe) |-> ##[1:8] !t_scl_oe)
		else $error("clock held low too long");
	sda_setup_a: assert property ($changed(t_sda_oe) |-> !scl)
		else $error("target data changed while clock high");
endmodule
`default_nettype wire

// file: verification/accel_i2c_register_port_tb.sv
/* bench: controller and target joined by one bus, random registers
 assumes: both ends share clk_i and rst_n_i */
`timescale 1ns/1ps
`default_nettype none
module accel_i2c_register_port_tb;
	import acc_pkg::*;
	localparam logic [7:0] PID = 8'h3c; // arbitrary value
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic sel = 1'b1;
	logic vld = 1'b0;
	logic rd = 1'b0;
	logic csel = 1'b1;
	logic mid = 1'b0;
	logic [11:0] ax = 12'h000;
	logic [11:0] ay = 12'h000;
	logic [11:0] az = 12'h000;
	logic [7:0] len = 8'h01;
	acc_byte_t ptr = 8'h00;
	acc_byte_t wd = 8'h00;
	acc_byte_t rdata, ctl1, rate;
	logic busy, wtake, rvld, nack, done, drdy;
	logic pscl = 1'b1;
	logic psda = 1'b1;
	logic [8:0] mon = 9'h100;
	logic [7:0] abyte;
	int n_st, n_sp, fail_count, compares;
	acc_byte_t wb[8];
	acc_byte_t rb[8];
	logic [11:0] v[3];
	acc_byte_t rw[8] = '{8'h1b, 8'h1d, 8'h1e, 8'h1f, 8'h21, 8'h29,
		8'h3a, 8'h6a};
	acc_bus_if bus();
	always #25 clk_i = ~clk_i;
	acc_target #(.RATE_BASE(8), .PART_ID(PID)) acc_target_inst (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus), .addr_sel_i(sel),
		.axis_x_i(ax), .axis_y_i(ay), .axis_z_i(az),
		.control_primary_o(ctl1), .rate_cfg_o(rate), .data_ready_o(drdy));
	acc_ctrl #(.QCYC(6)) acc_ctrl_inst (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus), .cmd_vld_i(vld),
		.cmd_rd_i(rd), .cmd_sel_i(csel), .cmd_ptr_i(ptr), .cmd_len_i(len),
		.wdata_i(wd), .busy_o(busy), .wtake_o(wtake), .rdata_o(rdata),
		.rvld_o(rvld), .nack_o(nack), .done_o(done));
	acc_bus_checker acc_bus_checker_inst (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_sel_i(sel),
		.t_scl_oe(bus.t_scl_oe), .t_sda_oe(bus.t_sda_oe),
		.scl(bus.scl), .sda(bus.sda));
	// ====
	// wire watcher: conditions and first byte after a start
	always @(negedge clk_i) begin
		if (pscl && bus.scl && psda && !bus.sda) begin
			n_st++;
			mon = 9'h001;
		end else if (pscl && bus.scl && !psda && bus.sda) begin
			n_sp++;
		end else if (!pscl && bus.scl && !mon[8]) begin
			mon = {mon[7:0], bus.sda};
			abyte = mon[7:0];
		end
		pscl = bus.scl;
		psda = bus.sda;
	end
	// ====
	// helpers
	function automatic logic [7:0] axb(input logic [11:0] s,
		input logic r, input logic h);
		return h ? s[11:4] : (r ? {s[3:0], 4'h0} : 8'h00);
	endfunction
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		if (fail_count == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic xfer(input logic r, input logic s, input acc_byte_t p,
		input int n);
		int wi;
		int ri;
		int t;
		logic tk;
		wi = 0;
		ri = 0;
		tk = 1'b0;
		n_st = 0;
		n_sp = 0;
		@(posedge clk_i);
		rd <= r;
		csel <= s;
		ptr <= p;
		len <= 8'(n);
		wd <= wb[0];
		vld <= 1'b1;
		@(posedge clk_i);
		vld <= 1'b0;
		for (t = 0; t < 9000; t++) begin
			if (tk && wi < 7) begin
				wi++;
				wd <= wb[wi];
			end
			if (mid && ri > 0) begin
				ax <= 12'h5a5;
				ay <= 12'h5a5;
				az <= 12'h5a5;
			end
			@(negedge clk_i);
			tk = wtake === 1'b1;
			if (rvld === 1'b1) begin
				rb[ri] = rdata;
				ri++;
			end
			if (done === 1'b1) break;
			@(posedge clk_i);
		end
		chk(done, 1'b1);
		chk(busy, 1'b0);
		chk(12'(n_sp), 12'h001);
		chk({bus.scl, bus.sda}, 2'b11);
		chk(nack, s != sel);
		if (s == sel) begin
			chk(12'(n_st), r ? 12'h002 : 12'h001);
			chk(abyte, {6'h07, s, r});
		end
	endtask
	// ====
	// watchdog
	initial begin
		repeat (90000) @(posedge clk_i);
		fail_count++;
		test_done();
	end
	// ====
	// main sequence
	initial begin
		void'($urandom(16));
		repeat (3) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		foreach (rw[i]) begin
			xfer(1'b1, sel, rw[i], 1);
			chk(rb[0], 8'h00);
			wb[0] = 8'($urandom());
			if (i == 0) wb[0][7] = 1'b0;
			xfer(1'b0, sel, rw[i], 1);
			xfer(1'b1, sel, rw[i], 1);
			chk(rb[0], wb[0]);
		end
		foreach (wb[i]) wb[i] = 8'($urandom());
		xfer(1'b0, sel, 8'h1c, 4);
		xfer(1'b1, sel, 8'h1c, 4);
		chk(rb[0], 8'h00);
		for (int i = 1; i < 4; i++) chk(rb[i], wb[i]);
		xfer(1'b0, sel, 8'h0c, 1);
		xfer(1'b1, sel, 8'h0c, 4);
		chk(rb[0], 8'h55);
		chk(rb[1], 8'h00);
		chk(rb[3], PID);
		for (int k = 0; k < 2; k++) begin
			@(posedge clk_i);
			sel <= k[0];
			repeat (4) @(posedge clk_i);
			wb[0] = 8'hff;
			xfer(1'b0, !sel, 8'h1d, 1);
			xfer(1'b1, sel, 8'h9d, 1);
			chk(rb[0], wb[1]);
		end
		for (int k = 0; k < 3; k++) begin
			v[0] = k == 0 ? 12'h800 : 12'($urandom());
			v[1] = k == 0 ? 12'h7ff : 12'($urandom());
			v[2] = 12'($urandom());
			@(posedge clk_i);
			ax <= v[0];
			ay <= v[1];
			az <= v[2];
			wb[0] = 8'h00;
			xfer(1'b0, sel, 8'h1b, 1);
			xfer(1'b0, sel, 8'h21, 1);
			wb[0] = {1'b1, k != 1, 6'h00};
			xfer(1'b0, sel, 8'h1b, 1);
			chk(ctl1, wb[0]);
			chk(rate, 8'h00);
			repeat (40) @(posedge clk_i);
			@(negedge clk_i);
			chk(drdy, 1'b1);
			xfer(1'b1, sel, 8'h16, 3);
			chk(rb[0], 8'h10);
			chk(rb[1], 8'h00);
			chk(rb[2], 8'h10);
			mid = 1'b1;
			xfer(1'b1, sel, 8'h06, 6);
			mid = 1'b0;
			for (int j = 0; j < 6; j++) begin
				chk(rb[j], axb(v[j/2], k != 1, j[0]));
			end
			repeat (40) @(posedge clk_i);
			xfer(1'b1, sel, 8'h06, 6);
			for (int j = 0; j < 6; j++) begin
				chk(rb[j], axb(12'h5a5, k != 1, j[0]));
			end
		end
		test_done();
	end
endmodule
`default_nettype wire
